// file: core/ebg_pkg.sv
// Purpose: shared constants for the external bus grant handshake
// Assumes: one clock, clk_sys at 125 MHz
// Notes:   processor cycle is a divided enable of clk_sys
package ebg_pkg;
   // clock figures
   localparam int CLK_PERIOD_PS     = 8000;
   // least request pulse width the master must give
   localparam int REQ_MIN_WIDTH_PS  = 10000;
   localparam int REQ_MIN_CYCLES    = (REQ_MIN_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // default processor cycle, in clk_sys cycles
   localparam int PROC_DIV_DEFAULT  = 4;
   // strobe idle (inactive) level
   localparam logic STROBE_IDLE     = 1'h1;
   localparam logic GRANT_IDLE      = 1'h1;

   typedef enum logic [1:0] {
      EBG_OWN,
      EBG_FLOAT,
      EBG_GRANTED,
      EBG_RELEASE
   } ebg_state_t;
endpackage

// file: core/ebg_cycle_div.sv
// Purpose: processor cycle enable and processor clock out from clk_sys
// Assumes: div is even and at least 2
// Notes:   clock out is high in the first half of each processor cycle
`timescale 1ns/1ps
module ebg_cycle_div #(
   parameter int DIV = ebg_pkg::PROC_DIV_DEFAULT
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // outputs
   output logic      cycle_start,
   output logic      mid_cycle,
   output logic      clock_out
);
   localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

   typedef struct packed {
      logic [CW-1:0] count;
      logic          start;
      logic          mid;
      logic          clk;
   } ebg_div_t;

   ebg_div_t st;
   ebg_div_t next_st;

   initial begin
      if (DIV < 2 || (DIV % 2) != 0) begin
         $error("ebg_cycle_div: DIV must be even and at least 2");
      end
   end

   always_comb begin
      next_st = st;
      if (st.count == CW'(DIV - 1)) begin
         next_st.count = '0;
      end else begin
         next_st.count = st.count + CW'(1);
      end
      next_st.start = (next_st.count == '0);
      next_st.mid   = (next_st.count == CW'(DIV / 2));
      next_st.clk   = (next_st.count < CW'(DIV / 2));
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign cycle_start = st.start;
   assign mid_cycle   = st.mid;
   assign clock_out   = st.clk;
endmodule

// file: core/ebg_handshake.sv
// Purpose: hands the external memory bus to another master on request
// Assumes: core strobes arrive active low; request may be asynchronous
// Notes:   decisions are taken once per processor cycle at its start
`timescale 1ns/1ps
// Functional notes
// [RULE1] The request is sampled every processor cycle and recognised in that cycle or the next.
// [RULE2] The outside master holds its request low for more than 10 ns.
// [RULE3] Grant goes low in the processor cycle after the request was recognised; the code drives it low one processor cycle later.
// [RULE4] An asynchronous request is synchronised inside, so no outside circuit is needed.
// [RULE5] All selects and strobes are floated no later than the edge on which grant goes low.
// [RULE6] Selects and strobes are driven again only after grant has gone high.
// [RULE7] Grant stays low while the request is held and is released once it is withdrawn.
module ebg_handshake #(
   parameter int PROC_DIV = ebg_pkg::PROC_DIV_DEFAULT
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // bus master link
   input  wire logic bus_request_n,
   output logic      bus_grant_n,
   output logic      processor_clock_out,
   // core side memory strobes, active low, and the active high bus held flag
   input  wire logic core_data_sel_n,
   input  wire logic core_prog_sel_n,
   input  wire logic core_boot_sel_n,
   input  wire logic core_rd_n,
   input  wire logic core_wr_n,
   output logic      core_bus_held,
   // memory pins: value and output enable
   output logic      data_mem_select_n,
   output logic      data_mem_select_oe,
   output logic      prog_mem_select_n,
   output logic      prog_mem_select_oe,
   output logic      boot_mem_select_n,
   output logic      boot_mem_select_oe,
   output logic      rd_n,
   output logic      rd_oe,
   output logic      wr_n,
   output logic      wr_oe
);
   typedef struct packed {
      logic               req_meta;
      logic               req_sync;
      logic               recognised;
      ebg_pkg::ebg_state_t fsm;
      logic               grant_n;
      logic               drive;
      logic               held;
      logic               clk_o;
      logic [4:0]         strobes;
   } ebg_core_t;

   ebg_core_t st;
   ebg_core_t next_st;
   logic      cyc_start;
   logic      cyc_mid;
   logic      div_clk;

   initial begin
      if (PROC_DIV * ebg_pkg::CLK_PERIOD_PS <= ebg_pkg::REQ_MIN_WIDTH_PS) begin
         $error("ebg_handshake: processor cycle shorter than least request width");
      end
   end

   ebg_cycle_div #(
      .DIV(PROC_DIV)
   ) u_div (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .cycle_start(cyc_start),
      .mid_cycle  (cyc_mid),
      .clock_out  (div_clk)
   );

   always_comb begin
      next_st = st;
      // [RULE4] two-flop synchroniser
      next_st.req_meta = ~bus_request_n;
      next_st.req_sync = st.req_meta;
      next_st.clk_o    = div_clk;
      next_st.strobes  = {core_data_sel_n, core_prog_sel_n, core_boot_sel_n, core_rd_n, core_wr_n};
      // [RULE1] sample mid cycle
      if (cyc_mid) begin
         next_st.recognised = st.req_sync;
      end
      if (cyc_start) begin
         unique case (st.fsm)
            ebg_pkg::EBG_OWN: begin
               // [RULE3] go to EBG_FLOAT next cycle, grant goes low one cycle later
               if (st.recognised) begin
                  next_st.fsm  = ebg_pkg::EBG_FLOAT;
                  next_st.held = 1'b1;
               end
            end
            ebg_pkg::EBG_FLOAT: begin
               // [RULE5] float on the same edge as grant
               next_st.drive   = 1'b0;
               next_st.grant_n = 1'b0;
               next_st.fsm     = ebg_pkg::EBG_GRANTED;
            end
            ebg_pkg::EBG_GRANTED: begin
               // [RULE7] hold until withdrawn
               if (!st.recognised) begin
                  next_st.grant_n = ebg_pkg::GRANT_IDLE;
                  next_st.fsm     = ebg_pkg::EBG_RELEASE;
               end
            end
            ebg_pkg::EBG_RELEASE: begin
               // [RULE6] drive after grant high
               next_st.drive = 1'b1;
               next_st.held  = 1'b0;
               next_st.fsm   = ebg_pkg::EBG_OWN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st         <= '0;
         st.fsm     <= ebg_pkg::EBG_OWN;
         st.grant_n <= ebg_pkg::GRANT_IDLE;
         st.drive   <= 1'b1;
         st.strobes <= {5{ebg_pkg::STROBE_IDLE}};
      end else begin
         st <= next_st;
      end
   end

   assign bus_grant_n         = st.grant_n;
   assign processor_clock_out = st.clk_o;
   assign core_bus_held       = st.held;
   assign data_mem_select_n   = st.strobes[4];
   assign prog_mem_select_n   = st.strobes[3];
   assign boot_mem_select_n   = st.strobes[2];
   assign rd_n                = st.strobes[1];
   assign wr_n                = st.strobes[0];
   assign data_mem_select_oe  = st.drive;
   assign prog_mem_select_oe  = st.drive;
   assign boot_mem_select_oe  = st.drive;
   assign rd_oe               = st.drive;
   assign wr_oe               = st.drive;
endmodule

// file: tb/ebg_handshake_sva.sv
// Purpose: port checks for the bus grant handshake
// Assumes: PROC_DIV of 4
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module ebg_handshake_sva #(
   parameter int PROC_DIV = 4
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic bus_request_n,
   input wire logic bus_grant_n,
   input wire logic core_bus_held,
   input wire logic data_mem_select_oe,
   input wire logic prog_mem_select_oe,
   input wire logic boot_mem_select_oe,
   input wire logic rd_oe,
   input wire logic wr_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic [4:0] oe = {data_mem_select_oe, prog_mem_select_oe, boot_mem_select_oe, rd_oe, wr_oe};
   sequence req_held; $fell(bus_request_n) ##1 !bus_request_n [*7]; endsequence
   sequence rel_held; $rose(bus_request_n) ##1 bus_request_n [*7]; endsequence
   a_oe_off_grant: assert property (!bus_grant_n |-> oe == 5'h00)
      else $error("pins driven under grant");
   a_oe_back_late: assert property ($rose(oe[0]) |-> $past(bus_grant_n))
      else $error("pins back before grant high");
   a_oe_all_same: assert property (oe == 5'h00 || oe == 5'h1F)
      else $error("enables differ");
   a_grant_kept: assert property (!bus_grant_n && !bus_request_n |=> !bus_grant_n)
      else $error("grant lost");
   a_grant_in_time: assert property (req_held |-> ##[0:12] !bus_grant_n)
      else $error("grant late");
   a_grant_not_early: assert property ($fell(bus_request_n) && bus_grant_n |-> bus_grant_n [*6])
      else $error("grant early");
   a_release_in_time: assert property (rel_held |-> ##[0:12] bus_grant_n)
      else $error("grant not released");
   a_held_grant: assert property (!bus_grant_n |-> core_bus_held)
      else $error("held low under grant");
endmodule

// file: tb/ebg_master_model.sv
// Purpose: outside master asking for the bus
// Assumes: grant is active low
// Notes:   holds its request for keep+1 clk_sys cycles after grant goes low
`timescale 1ns/1ps
module ebg_master_model (
   input  wire logic       clk_sys,
   input  wire logic       start,
   input  wire logic [7:0] keep,
   input  wire logic       bus_grant_n,
   output logic            bus_request_n
);
   logic [7:0] cnt = 8'h00;
   initial bus_request_n = 1'h1;
   always @(posedge clk_sys) begin
      if (start) begin
         bus_request_n <= 1'h0;
      end
      else if (!bus_grant_n && !bus_request_n) begin
         cnt <= cnt + 8'h01;
         if (cnt == keep) begin
            bus_request_n <= 1'h1;
            cnt <= 8'h00;
         end
      end
   end
endmodule

// file: tb/test_external_bus_grant_handshake.sv
// Purpose: self-checking bench for the bus grant handshake
// Assumes: PROC_DIV of 4
// Notes:   master model makes the requests
`timescale 1ns/1ps
module test_external_bus_grant_handshake;
   logic       clk_sys, rst_b, start;
   logic [7:0] keep;
   logic [4:0] core_n;
   wire  [4:0] pin_n, pin_oe;
   wire        bus_request_n, bus_grant_n, held, clk_out;
   int         error_cnt, n_tests, n;
   ebg_master_model mst_u (.clk_sys(clk_sys), .start(start), .keep(keep), .bus_grant_n(bus_grant_n),
      .bus_request_n(bus_request_n));
   ebg_handshake #(.PROC_DIV(4)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .bus_request_n(bus_request_n),
      .bus_grant_n(bus_grant_n), .processor_clock_out(clk_out), .core_data_sel_n(core_n[4]),
      .core_prog_sel_n(core_n[3]), .core_boot_sel_n(core_n[2]), .core_rd_n(core_n[1]), .core_wr_n(core_n[0]),
      .core_bus_held(held), .data_mem_select_n(pin_n[4]), .data_mem_select_oe(pin_oe[4]),
      .prog_mem_select_n(pin_n[3]), .prog_mem_select_oe(pin_oe[3]), .boot_mem_select_n(pin_n[2]),
      .boot_mem_select_oe(pin_oe[2]), .rd_n(pin_n[1]), .rd_oe(pin_oe[1]), .wr_n(pin_n[0]), .wr_oe(pin_oe[0]));
   task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic step();
      @(posedge clk_sys);
      #1;
      n++;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end
      else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic t_idle();
      core_n <= 5'h0A;
      repeat (3) step();
      chk("grant", 5'h01, {4'h0, bus_grant_n});
      chk("enables", 5'h1F, pin_oe);
      chk("strobes", 5'h0A, pin_n);
      $display("idle test done");
   endtask
   task automatic t_clock();
      int hi;
      int rises;
      logic prev;
      hi = 0;
      rises = 0;
      prev = clk_out;
      repeat (2 * ebg_pkg::PROC_DIV_DEFAULT) begin
         step();
         hi += int'(clk_out === 1'b1);
         rises += int'(clk_out === 1'b1 && prev === 1'b0);
         prev = clk_out;
      end
      chk("clock out high", 5'(ebg_pkg::PROC_DIV_DEFAULT), 5'(hi));
      chk("clock out rises", 5'h02, 5'(rises));
      $display("clock test done");
   endtask
   task automatic t_grant(input logic [7:0] k);
      @(posedge clk_sys);
      keep <= k;
      start <= 1'h1;
      @(posedge clk_sys);
      start <= 1'h0;
      n = 1;
      while (bus_grant_n !== 1'h0 && n < 40) step();
      chk("grant delay", 5'h01, {4'h0, n >= 5 && n < 20});
      chk("enables at grant", 5'h00, pin_oe);
      chk("held", 5'h01, {4'h0, held});
      n = 0;
      while (bus_grant_n !== 1'h1 && n < 80) step();
      chk("grant length", 5'h01, {4'h0, n >= k && bus_request_n});
      chk("enables at release", 5'h00, pin_oe);
      while (pin_oe !== 5'h1F && n < 80) step();
      chk("enables back", 5'h1F, pin_oe);
      $display("grant test done keep %0d", k);
   endtask
   initial begin
      clk_sys = 1'h0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      rst_b = 1'h0;
      start = 1'h0;
      keep = 8'h00;
      core_n = 5'h1F;
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'h1;
      t_idle();
      t_clock();
      t_grant(8'h00);
      t_grant(8'h14);
      t_grant(8'h03);
      conclude();
   end
   initial begin
      #20000;
      error_cnt++;
      conclude();
   end
endmodule
bind ebg_handshake ebg_handshake_sva #(.PROC_DIV(PROC_DIV)) chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
   .bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n), .core_bus_held(core_bus_held),
   .data_mem_select_oe(data_mem_select_oe), .prog_mem_select_oe(prog_mem_select_oe),
   .boot_mem_select_oe(boot_mem_select_oe), .rd_oe(rd_oe), .wr_oe(wr_oe));
